// ===== rtl/spp_port.sv
// spi port pin logic: master sequencer, slave shifter, receive buffer
//
// What this block does
// - master makes one clock per data bit
// - master clock toggles only during a word
// - slave ignores clock while select high
// - launch on one edge, sample on other
// - polarity and phase choose transfer format
// - slave select is active low chip select
// - select low while master is an error
// - flag outputs can drive remote slave select
// - master drives mosi, reads miso
// - slave reads mosi, drives miso
// - open drain option on miso output
// - slave out disable turns off miso
`timescale 1ns/10ps
module spp_port
   import spp_pkg::*;
#(
   parameter int WORD_W     = spp_pkg::WORD_W,
   parameter int FIFO_DEPTH = spp_pkg::FIFO_DEPTH,
   parameter int FLAG_N     = spp_pkg::FLAG_N
) (
   // system clock, reset, enable
   input  wire logic                clock,
   input  wire logic                nrst,
   input  wire logic                clk_en,
   // serial clock pin
   input  wire logic                link_clock,
   output logic                     serial_clock_out,
   output logic                     serial_clock_oe,
   // slave select and flags
   input  wire logic                slave_select_in_n,
   input  wire logic [FLAG_N-1:0]   flag_level,
   input  wire logic [FLAG_N-1:0]   flag_drive,
   output logic [FLAG_N-1:0]        flag_out,
   output logic [FLAG_N-1:0]        flag_oe,
   // data pins
   input  wire logic                mosi_in,
   output logic                     mosi_out,
   output logic                     mosi_oe,
   input  wire logic                miso_in,
   output logic                     miso_out,
   output logic                     miso_oe,
   // control
   input  wire logic [CTL_W-1:0]    port_control_register,
   input  wire logic [7:0]          half_period,
   input  wire logic                mm_error_clr,
   input  wire logic                rx_overrun_clr,
   // transmit words
   input  wire logic [WORD_W-1:0]   tx_data,
   input  wire logic                tx_valid,
   output logic                     tx_ready,
   // receive words
   output logic [WORD_W-1:0]        rx_data,
   output logic                     rx_valid,
   input  wire logic                rx_ready,
   // status
   output logic                     busy,
   output logic                     mm_error,
   output logic                     rx_overrun
);
   import spp_pkg::*;

   typedef struct packed {
      spp_mst_st_t       st;
      logic [7:0]        half;
      logic [7:0]        edges;
      logic              sclk;
      logic              sclk_oe;
      logic              mosi;
      logic              mosi_oe;
      logic [WORD_W-1:0] sh;
      logic [WORD_W-1:0] rx;
      logic              busy;
      logic              mm_err;
      logic              ovr;
      logic              tx_rdy;
      logic [WORD_W-1:0] slv_tx;
      logic [FLAG_N-1:0] flag;
      logic [FLAG_N-1:0] flag_en;
      logic              ss_s1;
      logic              ss_s2;
      logic              miso_s1;
      logic              miso_s2;
      logic              tgl_s1;
      logic              tgl_s2;
      logic              tgl_s3;
      logic              push_v;
      logic [WORD_W-1:0] push_d;
      logic              rxv;
      logic [WORD_W-1:0] rxd;
   } spp_sys_t;

   typedef struct packed {
      logic [7:0]        cnt;
      logic [WORD_W-1:0] sh;
   } spp_lnk_t;

   typedef struct packed {
      logic [WORD_W-1:0] hold;
      logic              tgl;
   } spp_word_t;

   spp_sys_t  q;
   spp_sys_t  d;
   spp_lnk_t  lq;
   spp_lnk_t  ld;
   spp_word_t wq;
   spp_word_t wd;
   logic [1:0] rst_sync;
   logic       rst_n;
   logic       master;
   logic       cpol;
   logic       cpha;
   logic       take;
   logic       ss_low;
   logic       mm_set;
   logic       ovr_set;
   logic       word_ev;
   logic       sample;
   logic       pop;
   logic [7:0] hp;
   logic       slave_clk;
   logic       lnk_rst;
   logic       slv_bit;
   logic [7:0] slv_idx;

   spp_fifo_if #(.W(WORD_W)) fifo_if ();

   spp_fifo #(
      .W     (WORD_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clock  (clock),
      .rst_n  (rst_n),
      .clk_en (clk_en),
      .f      (fifo_if.store)
   );

   // reset release through two flops
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rst_sync <= 2'h0;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   assign master  = port_control_register[CTL_MASTER] & port_control_register[CTL_EN];
   assign cpol    = port_control_register[CTL_CPOL];
   assign cpha    = port_control_register[CTL_CPHA];
   assign hp      = (half_period < HALF_MIN) ? HALF_MIN : half_period;
   assign ss_low  = !q.ss_s2;
   assign take    = tx_valid & q.tx_rdy;
   assign word_ev = q.tgl_s2 ^ q.tgl_s3;

   // buffer hookup
   assign fifo_if.wr_valid = q.push_v;
   assign fifo_if.wr_data  = q.push_d;
   assign pop              = fifo_if.rd_valid & (!q.rxv | rx_ready);
   assign fifo_if.rd_ready = pop;

   always_comb begin
      d        = q;
      mm_set   = 1'b0;
      ovr_set  = 1'b0;
      sample   = 1'b0;
      // pin synchronisers
      d.ss_s1   = slave_select_in_n;
      d.ss_s2   = q.ss_s1;
      d.miso_s1 = miso_in;
      d.miso_s2 = q.miso_s1;
      d.tgl_s1  = wq.tgl;
      d.tgl_s2  = q.tgl_s1;
      d.tgl_s3  = q.tgl_s2;
      // flag pins toward remote slave selects
      d.flag    = flag_level;
      d.flag_en = flag_drive;
      // buffer write handshake
      if (q.push_v && fifo_if.wr_ready) begin
         d.push_v = 1'b0;
      end
      // receive output stage
      if (q.rxv && rx_ready) begin
         d.rxv = 1'b0;
      end
      if (pop) begin
         d.rxv = 1'b1;
         d.rxd = fifo_if.rd_data;
      end
      // master sequencer
      case (q.st)
         SPP_IDLE: begin
            d.sclk = cpol;
            d.half = HALF_RST;
            if (take && master) begin
               d.st    = SPP_RUN;
               d.busy  = 1'b1;
               d.edges = 8'h00;
               d.sh    = tx_data;
               if (!cpha) begin
                  d.mosi = tx_data[WORD_W-1];
                  d.sh   = {tx_data[WORD_W-2:0], 1'b0};
               end
            end
         end
         SPP_RUN: begin
            if (q.half == hp - 8'h01) begin
               d.half = HALF_RST;
               if (q.edges == 8'(2*WORD_W)) begin
                  d.st     = SPP_IDLE;
                  d.busy   = 1'b0;
                  d.push_v = 1'b1;
                  d.push_d = q.rx;
               end else begin
                  d.sclk  = ~q.sclk;
                  d.edges = q.edges + 8'h01;
                  sample  = (q.edges[0] == cpha);
                  if (sample) begin
                     d.rx = {q.rx[WORD_W-2:0], q.miso_s2};
                  end else begin
                     d.mosi = q.sh[WORD_W-1];
                     d.sh   = {q.sh[WORD_W-2:0], 1'b0};
                  end
               end
            end else begin
               d.half = q.half + 8'h01;
            end
         end
         default: begin
            d.st   = SPP_IDLE;
            d.busy = 1'b0;
         end
      endcase
      // another master pulls our select low
      mm_set = master & ss_low;
      if (mm_set) begin
         d.st   = SPP_IDLE;
         d.busy = 1'b0;
         d.sclk = cpol;
      end
      d.mm_err = mm_set | (q.mm_err & !mm_error_clr);
      // master owns clock and mosi
      d.sclk_oe = master & !d.mm_err;
      d.mosi_oe = master & !d.mm_err;
      // slave transmit word, loaded only while deselected
      if (take && !master) begin
         d.slv_tx = tx_data;
      end
      // slave words arriving from the link
      if (word_ev && !master) begin
         if (d.push_v) begin
            ovr_set = 1'b1;
         end else begin
            d.push_v = 1'b1;
            d.push_d = wq.hold;
         end
      end
      d.ovr = ovr_set | (q.ovr & !rx_overrun_clr);
      // registered transmit ready
      if (master) begin
         d.tx_rdy = (d.st == SPP_IDLE) & !take & !d.mm_err & !d.push_v
                    & fifo_if.wr_ready & port_control_register[CTL_EN];
      end else begin
         d.tx_rdy = q.ss_s2 & port_control_register[CTL_EN];
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         q      <= '0;
         q.ss_s1 <= 1'b1;
         q.ss_s2 <= 1'b1;
      end else if (clk_en) begin
         q <= d;
      end
   end

   // slave side on the link clock
   assign slave_clk = link_clock ^ (cpol ^ cpha);
   assign lnk_rst   = !rst_n | slave_select_in_n | master;

   always_comb begin
      ld    = lq;
      wd    = wq;
      ld.sh = {lq.sh[WORD_W-2:0], mosi_in};
      if (lq.cnt == 8'(WORD_W-1)) begin
         ld.cnt  = 8'h00;
         wd.hold = {lq.sh[WORD_W-2:0], mosi_in};
         wd.tgl  = ~wq.tgl;
      end else begin
         ld.cnt = lq.cnt + 8'h01;
      end
   end

   // bit counter and shifter, cleared while deselected
   always_ff @(posedge slave_clk or posedge lnk_rst) begin
      if (lnk_rst) begin
         lq <= '0;
      end else begin
         lq <= ld;
      end
   end

   // finished word and its event toggle survive deselect
   always_ff @(posedge slave_clk or negedge rst_n) begin
      if (!rst_n) begin
         wq <= '0;
      end else if (!lnk_rst) begin
         wq <= wd;
      end
   end

   // slave output bit follows the sampled bit count
   assign slv_idx = 8'(WORD_W-1) - lq.cnt;
   assign slv_bit = q.slv_tx[slv_idx[$clog2(WORD_W)-1:0]];

   assign miso_out = port_control_register[CTL_OPD] ? 1'b0 : slv_bit;
   assign miso_oe  = !master & port_control_register[CTL_EN]
                     & !slave_select_in_n
                     & !port_control_register[CTL_SOD]
                     & (!port_control_register[CTL_OPD] | !slv_bit);

   // pin and status outputs
   assign serial_clock_out = q.sclk;
   assign serial_clock_oe  = q.sclk_oe;
   assign mosi_out         = q.mosi;
   assign mosi_oe          = q.mosi_oe;
   assign flag_out         = q.flag;
   assign flag_oe          = q.flag_en;
   assign tx_ready         = q.tx_rdy;
   assign rx_data          = q.rxd;
   assign rx_valid         = q.rxv;
   assign busy             = q.busy;
   assign mm_error         = q.mm_err;
   assign rx_overrun       = q.ovr;
endmodule : spp_port

// ===== common/spp_pkg.sv
// constants and types shared by the spi port pin logic
package spp_pkg;
   // word, buffer, flag and control sizes
   localparam int WORD_W     = 8;
   localparam int FIFO_DEPTH = 4;
   localparam int FLAG_N     = 4;
   localparam int CTL_W      = 8;

   // port_control_register field positions
   localparam int CTL_MASTER = 0;
   localparam int CTL_CPOL   = 1;
   localparam int CTL_CPHA   = 2;
   localparam int CTL_OPD    = 3;
   localparam int CTL_EN     = 4;
   localparam int CTL_SOD    = 5;

   // reset values and timing counts
   localparam logic [7:0] CTL_RESET = 8'h00;
   localparam logic [7:0] HALF_MIN  = 8'h03;
   localparam logic [7:0] HALF_RST  = 8'h00;

   // master sequencer states
   typedef enum logic [1:0] {
      SPP_IDLE,
      SPP_RUN
   } spp_mst_st_t;
endpackage : spp_pkg

// ===== common/spp_fifo_if.sv
// handshake bundle between the port logic and its receive buffer
`timescale 1ns/10ps
interface spp_fifo_if #(
   parameter int W = 8
);
   logic [W-1:0] wr_data;
   logic         wr_valid;
   logic         wr_ready;
   logic [W-1:0] rd_data;
   logic         rd_valid;
   logic         rd_ready;

   modport ctl (
      output wr_data, wr_valid, rd_ready,
      input  wr_ready, rd_data, rd_valid
   );
   modport store (
      input  wr_data, wr_valid, rd_ready,
      output wr_ready, rd_data, rd_valid
   );
endinterface : spp_fifo_if

// ===== rtl/spp_fifo.sv
// receive word buffer with valid and ready on both sides
`timescale 1ns/10ps
module spp_fifo #(
   parameter int W     = 8,
   parameter int DEPTH = 4
) (
   // clock and control
   input wire logic clock,
   input wire logic rst_n,
   input wire logic clk_en,
   // buffer ports
   spp_fifo_if.store f
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0]           wp;
      logic [AW-1:0]           rp;
      logic [AW:0]             cnt;
   } spp_fifo_st_t;

   spp_fifo_st_t q;
   spp_fifo_st_t d;
   logic         push;
   logic         pop;

   assign f.wr_ready = (q.cnt != (AW+1)'(DEPTH));
   assign f.rd_valid = (q.cnt != '0);
   assign f.rd_data  = q.mem[q.rp];

   always_comb begin
      d    = q;
      push = f.wr_valid & f.wr_ready;
      pop  = f.rd_valid & f.rd_ready;
      if (push) begin
         d.mem[q.wp] = f.wr_data;
         d.wp = (q.wp == AW'(DEPTH-1)) ? '0 : q.wp + 1'b1;
      end
      if (pop) begin
         d.rp = (q.rp == AW'(DEPTH-1)) ? '0 : q.rp + 1'b1;
      end
      if (push && !pop) begin
         d.cnt = q.cnt + 1'b1;
      end else if (pop && !push) begin
         d.cnt = q.cnt - 1'b1;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else if (clk_en) begin
         q <= d;
      end
   end
endmodule : spp_fifo

// ===== test/spp_port_properties.sv
// timing checks on the spi port pins
`timescale 1ns/10ps
module spp_port_properties
   import spp_pkg::*;
#(
   parameter int WORD_W = 8,
   parameter int FLAG_N = 4
) (
   // clock, reset, inputs
   input wire logic              clock,
   input wire logic              nrst,
   input wire logic [CTL_W-1:0]  port_control_register,
   input wire logic              slave_select_in_n,
   input wire logic [FLAG_N-1:0] flag_level,
   input wire logic [FLAG_N-1:0] flag_drive,
   input wire logic [FLAG_N-1:0] flag_oe,
   // pins and status
   input wire logic [FLAG_N-1:0] flag_out,
   input wire logic              serial_clock_out,
   input wire logic              serial_clock_oe,
   input wire logic              mosi_oe,
   input wire logic              miso_out,
   input wire logic              miso_oe,
   input wire logic              busy,
   input wire logic              mm_error
);
   logic [CTL_W-1:0] c;
   logic [7:0]       tog_q;
   logic             sck_q;
   logic [1:0]       age_q;
   assign c = port_control_register;
   // serial clock toggles per transfer
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         tog_q <= 8'h00;
         sck_q <= 1'b0;
         age_q <= 2'h0;
      end else begin
         sck_q <= serial_clock_out;
         tog_q <= busy ? tog_q + 8'(serial_clock_out != sck_q) : 8'h00;
         age_q <= (age_q == 2'h3) ? age_q : age_q + 2'h1;
      end
   end
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!nrst);
   sclk_idle_a: assert property (
      serial_clock_oe && !busy && !$past(busy) && $stable(c) && c == $past(c, 2)
      |-> serial_clock_out == c[CTL_CPOL]) else $error("serial clock not idle");
   sclk_gate_a: assert property (
      serial_clock_oe && $stable(c) && c == $past(c, 2) && serial_clock_out != sck_q
      |-> busy || $past(busy)) else $error("serial clock moved outside a word");
   clk_count_a: assert property (
      $fell(busy) && !mm_error |-> tog_q == 8'(2 * WORD_W))
      else $error("wrong clock edge count per word");
   mm_set_a: assert property (
      (c[CTL_MASTER] && c[CTL_EN] && !slave_select_in_n) [*3] |-> ##[0:2] mm_error)
      else $error("multimaster error not flagged");
   mm_drop_a: assert property (
      mm_error && $past(mm_error) && $past(mm_error, 2) |-> !serial_clock_oe && !mosi_oe)
      else $error("drivers kept on after multimaster error");
   miso_rel_a: assert property (slave_select_in_n |-> !miso_oe)
      else $error("miso driven while unselected");
   miso_off_a: assert property (c[CTL_SOD] |-> !miso_oe)
      else $error("miso driven while disabled");
   open_drain_a: assert property (c[CTL_OPD] && miso_oe |-> !miso_out)
      else $error("miso driven high in open drain");
   mst_dir_a: assert property (c[CTL_MASTER] |-> !miso_oe)
      else $error("master drives miso");
   slv_dir_a: assert property (
      !c[CTL_MASTER] && !$past(c[CTL_MASTER]) |-> !mosi_oe && !serial_clock_oe)
      else $error("slave drives mosi or clock");
   flag_copy_a: assert property (
      age_q == 2'h3 |-> flag_out == $past(flag_level) && flag_oe == $past(flag_drive))
      else $error("flag output not following request");
   cover property ($fell(busy));
   cover property ($rose(mm_error));
   cover property (!slave_select_in_n && miso_oe);
endmodule : spp_port_properties

bind spp_port spp_port_properties #(.WORD_W(WORD_W), .FLAG_N(FLAG_N)) u_props (
   .clock, .nrst, .port_control_register, .slave_select_in_n, .flag_level, .flag_out,
   .flag_drive, .flag_oe,
   .serial_clock_out, .serial_clock_oe, .mosi_oe, .miso_out, .miso_oe, .busy, .mm_error
);

// ===== test/spp_slave_model.sv
// far-side slave clocked by the device's master clock
`timescale 1ns/10ps
module spp_slave_model (
   // link pins
   input wire logic       sclk,
   input wire logic       sel_n,
   input wire logic       mosi,
   output logic           miso,
   // word setup
   input wire logic       cpha,
   input wire logic [7:0] tx,
   output logic [7:0]     rx
);
   int   idx;
   int   ns;
   logic ob;
   always @(negedge sel_n) begin
      idx = 0;
      ns  = 0;
      ob  = tx[7];
   end
   always @(sclk) begin
      if (!sel_n) begin
         if (idx % 2 == int'(cpha)) begin
            rx = {rx[6:0], mosi};
            ns++;
         end else if (ns < 8) begin
            ob = tx[7 - ns];
         end
         idx++;
      end
   end
   assign miso = sel_n ? 1'b1 : ob;
endmodule : spp_slave_model

// ===== test/tb.sv
// self-checking bench for the spi port pin logic
`timescale 1ns/10ps
module tb;
   import spp_pkg::*;
   logic       clock, nrst, link_clock, slave_select_in_n, mosi_in, mm_error_clr;
   logic       tx_valid, rx_ready, rx_valid, tx_ready, busy, mm_error, s_miso;
   logic       clk_en, rx_overrun;
   logic       serial_clock_out, serial_clock_oe, mosi_out, mosi_oe, miso_out, miso_oe;
   logic [3:0] flag_level, flag_out, flag_drive, flag_oe;
   logic [7:0] ctl, tx_data, rx_data, rnd, s_tx, s_rx;
   int         n_errors, checks, cyc;
   logic [7:0] exp_q[$];
   wire        sclk_w = serial_clock_oe ? serial_clock_out : 1'b1;
   wire        mosi_w = mosi_oe ? mosi_out : 1'b1;
   wire        miso_in = miso_oe ? miso_out : s_miso;

   spp_port u_dut (
      .clock, .nrst, .clk_en, .link_clock, .serial_clock_out, .serial_clock_oe,
      .slave_select_in_n, .flag_level, .flag_drive, .flag_out, .flag_oe,
      .mosi_in, .mosi_out, .mosi_oe, .miso_in, .miso_out, .miso_oe,
      .port_control_register(ctl), .half_period(8'h04), .mm_error_clr,
      .rx_overrun_clr(1'b0), .tx_data, .tx_valid, .tx_ready, .rx_data, .rx_valid,
      .rx_ready, .busy, .mm_error, .rx_overrun
   );
   spp_slave_model u_far (
      .sclk(sclk_w), .sel_n(flag_out[0]), .mosi(mosi_w), .miso(s_miso),
      .cpha(ctl[CTL_CPHA]), .tx(s_tx), .rx(s_rx)
   );

   function automatic logic [7:0] nxt(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : nxt
   task automatic wrap_up;
      if (n_errors == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : wrap_up
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      checks++;
      if (g !== e) begin
         $display("unexpected %s: expected %h, seen %h", nm, e, g);
         n_errors++;
      end
   endtask : chk
   task automatic wt(ref logic s);
      for (int i = 0; i < 400; i++) begin
         @(negedge clock);
         if (s === 1'b1) return;
      end
      chk("handshake", 8'h01, 8'(s));
   endtask : wt
   task automatic send(input logic [7:0] w);
      wt(tx_ready);
      @(posedge clock);
      tx_data  <= w;
      tx_valid <= 1'b1;
      @(posedge clock);
      while (tx_ready !== 1'b1) @(posedge clock);
      tx_valid <= 1'b0;
   endtask : send
   task automatic get;
      wt(rx_valid);
      chk("rx_data", exp_q.pop_front(), rx_data);
      @(posedge clock);
      rx_ready <= 1'b1;
      @(posedge clock);
      rx_ready <= 1'b0;
   endtask : get
   task automatic frame(input logic [7:0] w, input logic [7:0] d, input logic sod);
      repeat (3) begin
         #24 link_clock = 1'b1;
         mosi_in = ~mosi_in;
         #24 link_clock = 1'b0;
      end
      #24 slave_select_in_n = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         mosi_in = d[i];
         #24 chk("miso pin", sod ? 1'b1 : w[i], miso_oe ? miso_out : 1'b1);
         link_clock = 1'b1;
         #24 link_clock = 1'b0;
      end
      #24 slave_select_in_n = 1'b1;
      #1 chk("miso_oe", 8'h00, miso_oe);
   endtask : frame

   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   always @(posedge clock) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         wrap_up();
      end
   end
   initial begin
      nrst = 1'b0;
      link_clock = 1'b0;
      slave_select_in_n = 1'b1;
      mosi_in = 1'b0;
      mm_error_clr = 1'b0;
      tx_valid = 1'b0;
      rx_ready = 1'b0;
      flag_level = 4'hf;
      flag_drive = 4'hf;
      clk_en = 1'b1;
      ctl = 8'h00;
      tx_data = 8'h00;
      s_tx = 8'h00;
      rnd = 8'h27;
      repeat (10) @(posedge clock);
      nrst <= 1'b1;
      repeat (4) @(posedge clock);
      for (int m = 0; m < 4; m++) begin
         ctl <= 8'h11 | 8'(m << CTL_CPOL);
         repeat (3) @(posedge clock);
         rnd = nxt(rnd);
         s_tx <= rnd;
         flag_level <= {rnd[6:4], 1'b0};
         flag_drive <= {rnd[2:0], 1'b1};
         exp_q.push_back(rnd);
         rnd = nxt(rnd);
         repeat (4) @(posedge clock);
         send(rnd);
         if (m == 1) begin
            @(posedge clock);
            clk_en <= 1'b0;
            repeat (7) @(negedge clock);
            chk("frozen pins", {5'h00, 2'b11, rnd[7]}, {5'h00, busy, serial_clock_out, mosi_out});
            @(posedge clock);
            clk_en <= 1'b1;
         end
         get();
         chk("far rx", rnd, s_rx);
         flag_level <= 4'hf;
         @(posedge clock);
      end
      @(posedge clock);
      slave_select_in_n <= 1'b0;
      wt(mm_error);
      chk("mm_error", 8'h01, mm_error);
      @(negedge clock);
      chk("serial_clock_oe", 8'h00, serial_clock_oe);
      @(posedge clock);
      slave_select_in_n <= 1'b1;
      repeat (4) @(posedge clock);
      mm_error_clr <= 1'b1;
      @(posedge clock);
      mm_error_clr <= 1'b0;
      @(negedge clock);
      chk("mm_error", 8'h00, mm_error);
      for (int f = 0; f < 3; f++) begin
         @(posedge clock);
         ctl <= 8'h10 | (8'(f == 1) << CTL_OPD) | (8'(f == 2) << CTL_SOD);
         rnd = nxt(rnd);
         send(rnd);
         exp_q.push_back(nxt(rnd));
         frame(rnd, nxt(rnd), 1'(f == 2));
         get();
      end
      chk("rx_overrun", 8'h00, 8'(rx_overrun));
      wrap_up();
   end
endmodule : tb
